// file: ossc_consts.svh
`ifndef OSSC_CONSTS_SVH
`define OSSC_CONSTS_SVH

// ****************************************
// widths and reset values
// ****************************************
`define OSSC_NCHAN       8
`define OSSC_MSB         7
`define OSSC_CMD_RST     8'hff
`define OSSC_SR_RST      8'h00
`define OSSC_ZERO8       8'h00
`define OSSC_CNT_W       16
`define OSSC_CNT_ZERO    16'h0000
`define OSSC_CNT_ONE     16'h0001
`define OSSC_SYNC3_RST   3'h4
`define OSSC_SYNC2_RST   2'h2

// ****************************************
// timing
// ****************************************
`define OSSC_CLK_NS       4
`define OSSC_FAULT_DLY_NS 150000

`endif

// file: ossc_pkg.sv
package ossc_pkg;
  typedef logic [7:0]  ossc_chan_t;
  typedef logic [15:0] ossc_cnt_t;
endpackage

// file: ossc_pin_if.sv
`timescale 1ns/1ps
// ****************************************
// synchronised pin events, sampler to core
// ****************************************
interface ossc_pin_if;
  logic cs_high;
  logic cs_rise;
  logic cs_fall;
  logic sclk_rise;
  logic sclk_fall;
  logic si_lvl;
  modport src (output cs_high, cs_rise, cs_fall, sclk_rise, sclk_fall, si_lvl);
  modport dst (input  cs_high, cs_rise, cs_fall, sclk_rise, sclk_fall, si_lvl);
endinterface

// file: ossc_pin_sync.sv
`timescale 1ns/1ps
`include "ossc_consts.svh"

// ****************************************
// two-flop sampling of the serial pins plus edge finding
// ****************************************
module ossc_pin_sync
  import ossc_pkg::*;
(
  input  wire logic  clock_i,
  input  wire logic  reset_n_i,
  input  wire logic  cs_n_i,
  input  wire logic  sclk_i,
  input  wire logic  si_i,
  ossc_pin_if.src    ev
);
  logic [2:0] meta_r, meta_nxt;
  logic [2:0] sync_r, sync_nxt;
  logic [1:0] prev_r, prev_nxt;

  // chip select idles high so its sync flops reset high, no false edge
  always_comb begin
    meta_nxt = {cs_n_i, sclk_i, si_i};
    sync_nxt = meta_r;
    prev_nxt = sync_r[2:1];
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      meta_r <= `OSSC_SYNC3_RST;
      sync_r <= `OSSC_SYNC3_RST;
      prev_r <= `OSSC_SYNC2_RST;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
      prev_r <= prev_nxt;
    end
  end

  // edges come from the second stage and its delayed copy, never the metastable one
  assign ev.cs_high   = sync_r[2];
  assign ev.cs_rise   = sync_r[2] & ~prev_r[1];
  assign ev.cs_fall   = ~sync_r[2] & prev_r[1];
  assign ev.sclk_rise = sync_r[1] & ~prev_r[0];
  assign ev.sclk_fall = ~sync_r[1] & prev_r[0];
  assign ev.si_lvl    = sync_r[0];
endmodule

// file: ossc_top.sv
`timescale 1ns/1ps
`include "ossc_consts.svh"

// Functional notes
// R1: eight low-side channels, driven by an eight-bit serial command word.
// R2: command bit zero turns a channel on, one turns it off.
// R3: each command transfer returns the drain status of every channel.
// R4: full duplex, one bit in and one bit out per serial clock.
// R5: daisy chains share one chip select; four devices give 32 channels.
// R6: host may instead give each device its own chip select.
// R7: each channel is controlled and faulted independently of the others.
// R8: with latching on, a short on an on channel reports after a delay.
// R9: channel disabled by a fault seen while selection is idle reports disabled.
// R10: select rise latches command to outputs; select fall loads status, enables output.
// R11: sample input on clock fall, shift output on rise; idle select ignores clock.
// R12: words move msb first, channel 7 first, eight bits per word.
// R13: reset clears the shift register and turns all channels off, not serial out.
// R14: received bits leave serial out after own eight; last eight latch.
// R15: status reads one for off and healthy, zero for on and healthy.

module ossc_top
  import ossc_pkg::*;
#(
  parameter int unsigned FAULT_DLY_CYC = `OSSC_FAULT_DLY_NS / `OSSC_CLK_NS
)
(
  input  wire logic        clock_i,
  input  wire logic        reset_n_i,
  input  wire logic        cs_n_i,
  input  wire logic        sclk_i,
  input  wire logic        si_i,
  input  wire logic        short_fault_latch_disable_i,
  input  wire ossc_chan_t  short_i,
  input  wire ossc_chan_t  open_load_i,
  output ossc_chan_t       chan_on_o,
  output logic             so_o,
  output logic             so_oe_o
);
  ossc_pin_if ev ();

  // ****************************************
  // pin sampling
  // ****************************************
  ossc_pin_sync u_sync (
    .clock_i   (clock_i),
    .reset_n_i (reset_n_i),
    .cs_n_i    (cs_n_i),
    .sclk_i    (sclk_i),
    .si_i      (si_i),
    .ev        (ev)
  );

  logic       sfld_meta_r;
  logic       sfld_r;
  ossc_chan_t sr_r, sr_nxt;
  ossc_chan_t cmd_r, cmd_nxt;
  logic       oe_r, oe_nxt;
  logic       so_r, so_nxt;
  ossc_chan_t short_lat_r, short_lat_nxt;
  ossc_chan_t open_lat_r, open_lat_nxt;
  ossc_cnt_t  dly_cnt_r, dly_cnt_nxt;
  logic       dly_run_r, dly_run_nxt;
  ossc_chan_t on_eff;
  ossc_chan_t status;
  logic       latch_en;

  // latch-disable strap is a pin: two flops, nothing reads the first
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sfld_meta_r <= 1'b0;
      sfld_r      <= 1'b0;
    end else begin
      sfld_meta_r <= short_fault_latch_disable_i;
      sfld_r      <= sfld_meta_r;
    end
  end

  // ****************************************
  // channel state and drain status
  // ****************************************
  // each bit uses only its own channel's inputs; no cross-channel terms
  always_comb begin
    latch_en = ~sfld_r;
    on_eff   = ~cmd_r & ~short_lat_r & ~open_lat_r;            // see R2 see R7
    // on: drain high only when shorted; off: drain pulled low by open load
    status   = (on_eff & short_i) | (~on_eff & ~open_load_i & ~open_lat_r); // see R15 see R9
  end

  assign chan_on_o = on_eff;                                   // see R1

  // ****************************************
  // fault latching
  // ****************************************
  // a fresh command clears latches and restarts the report delay, so an
  // in-rush short on a lamp is not caught before the delay runs out
  always_comb begin
    short_lat_nxt = short_lat_r;
    open_lat_nxt  = open_lat_r;
    dly_cnt_nxt   = dly_cnt_r;
    dly_run_nxt   = dly_run_r;
    if (ev.cs_rise) begin
      short_lat_nxt = `OSSC_ZERO8;
      open_lat_nxt  = `OSSC_ZERO8;
      dly_cnt_nxt   = `OSSC_CNT_ZERO;
      dly_run_nxt   = 1'b1;                                    // see R8
    end else begin
      if (dly_run_r) begin
        if (dly_cnt_r == `OSSC_CNT_W'(FAULT_DLY_CYC - 1)) begin
          dly_run_nxt = 1'b0;
        end else begin
          dly_cnt_nxt = dly_cnt_r + `OSSC_CNT_ONE;
        end
      end else if (latch_en) begin
        short_lat_nxt = short_lat_r | (short_i & ~cmd_r);      // see R8
      end
      if (ev.cs_high) begin
        open_lat_nxt = open_lat_r | (open_load_i & ~cmd_r);    // see R9
      end
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      short_lat_r <= `OSSC_ZERO8;
      open_lat_r  <= `OSSC_ZERO8;
      dly_cnt_r   <= `OSSC_CNT_ZERO;
      dly_run_r   <= 1'b0;
    end else begin
      short_lat_r <= short_lat_nxt;
      open_lat_r  <= open_lat_nxt;
      dly_cnt_r   <= dly_cnt_nxt;
      dly_run_r   <= dly_run_nxt;
    end
  end

  // ****************************************
  // shift register and command latch
  // ****************************************
  // sclk events only count while selected; the host keeps sclk low at
  // select edges, so a select edge and a clock edge never coincide
  always_comb begin
    sr_nxt  = sr_r;
    cmd_nxt = cmd_r;
    oe_nxt  = oe_r;
    if (ev.cs_rise) begin
      cmd_nxt = sr_r;                                          // see R10 see R14
      oe_nxt  = 1'b0;                                          // see R11
    end else if (ev.cs_fall) begin
      sr_nxt = status;                                         // see R3 see R10
      oe_nxt = 1'b1;                                           // see R10
    end else if (!ev.cs_high && ev.sclk_fall) begin
      sr_nxt = {sr_r[`OSSC_MSB-1:0], ev.si_lvl};               // see R4 see R12 see R5
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sr_r  <= `OSSC_SR_RST;                                   // see R13
      cmd_r <= `OSSC_CMD_RST;                                  // see R13
      oe_r  <= 1'b0;
    end else begin
      sr_r  <= sr_nxt;
      cmd_r <= cmd_nxt;
      oe_r  <= oe_nxt;
    end
  end

  // ****************************************
  // serial output
  // ****************************************
  // reset leaves the serial data flop alone, so it has no reset term
  always_comb begin
    so_nxt = so_r;
    if (ev.cs_fall) begin
      so_nxt = status[`OSSC_MSB];                              // see R12
    end else if (!ev.cs_high && ev.sclk_rise) begin
      so_nxt = sr_r[`OSSC_MSB];                                // see R11 see R14
    end
  end

  always_ff @(posedge clock_i) begin
    so_r <= so_nxt;                                            // see R13
  end

  // gated low when released so the port never shows an unknown level
  assign so_o    = oe_r & so_r;
  assign so_oe_o = oe_r;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);

  sequence sel_rise_s;
    ev.cs_rise;
  endsequence

  sequence sel_fall_s;
    ev.cs_fall;
  endsequence

  cmd_latch_a: assert property (sel_rise_s |=> cmd_r == $past(sr_r)) // see R10
    else $error("command not latched at select rise");

  status_load_a: assert property (sel_fall_s |=> sr_r == $past(status) && oe_r) // see R10
    else $error("status not loaded at select fall");

  so_release_a: assert property (sel_rise_s |=> !so_oe_o ##1 !so_oe_o) // see R11
    else $error("serial output still driven after select rise");

  shift_in_a: assert property (!ev.cs_high && ev.sclk_fall && !ev.cs_fall |=> // see R12
    sr_r == {$past(sr_r[`OSSC_MSB-1:0]), $past(ev.si_lvl)})
    else $error("input bit not shifted in msb first");

  so_shift_a: assert property (!ev.cs_high && ev.sclk_rise && !ev.cs_fall |=> // see R11
    so_r == $past(sr_r[`OSSC_MSB]))
    else $error("serial output did not follow register msb");

  idle_ignore_a: assert property (ev.cs_high && !ev.cs_rise |=> $stable(sr_r)) // see R11
    else $error("shift register moved while deselected");

  inverted_cmd_a: assert property (sel_rise_s |=> chan_on_o == ~$past(sr_r)) // see R2
    else $error("channel drive does not follow the inverted command");

  fault_delay_a: assert property (sel_rise_s |=> (short_lat_r == `OSSC_ZERO8) // see R8
    throughout (dly_run_r [*8]))
    else $error("short latched before the report delay");
endmodule

// file: ossc_host_model.sv
`timescale 1ns/1ps
// ****************************************
// host master: one chip select, 48 ns serial clock
// ****************************************
module ossc_host_model
  import ossc_pkg::*;
(
  input  wire logic  clock_i,
  input  wire logic  so_i,
  input  wire logic  so_oe_i,
  output logic       cs_n_o,
  output logic       sclk_o,
  output logic       si_o,
  output ossc_cnt_t  rx_word_o,
  output logic       rx_valid_o
);
  logic line_w;
  logic last_r;
  // a released line shows the inverse of its last value, never a stale copy
  assign line_w = so_oe_i ? so_i : ~last_r;
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    si_o = 1'b0;
    rx_word_o = 16'h0000;
    rx_valid_o = 1'b0;
    last_r = 1'b0;
  end
  // half a serial period, six system clocks
  task automatic half();
    repeat (6) @(negedge clock_i);
  endtask
  // one frame; a chain shares this single select line
  task automatic xfer(input ossc_cnt_t tx, input int nbits);
    rx_word_o = 16'h0000;
    cs_n_o = 1'b0;  // clock is low on select edges
    half();
    for (int i = nbits - 1; i >= 0; i--) begin
      si_o = tx[i];  // msb first
      sclk_o = 1'b1;
      half();
      sclk_o = 1'b0;  // one bit each way per clock
      rx_word_o = {rx_word_o[14:0], line_w};
      last_r = line_w;
      half();
    end
    cs_n_o = 1'b1;
    si_o = ~si_o;  // ignored data wiggles while deselected
    rx_valid_o = 1'b1;
    @(negedge clock_i);
    rx_valid_o = 1'b0;
    half();
  endtask
endmodule

// file: octal_switch_serial_control_tb.sv
`timescale 1ns/1ps
module octal_switch_serial_control_tb;
  import ossc_pkg::*;
  localparam int unsigned DLY = 20;
  logic        clock_i;
  logic        reset_n_i;
  logic        sfld;
  logic        cs_n;
  logic        sclk;
  logic        si;
  logic        so;
  logic        so_oe;
  logic        rx_valid;
  ossc_chan_t  short_v;
  ossc_chan_t  open_v;
  ossc_chan_t  chan_on;
  ossc_chan_t  cmd;
  ossc_chan_t  on_exp;
  ossc_chan_t  lat_exp;
  ossc_cnt_t   rx_word;
  ossc_cnt_t   exp_q[$];
  int          miscompares = 0;
  int          num_checks = 0;

  ossc_top #(.FAULT_DLY_CYC(DLY)) dut (.clock_i(clock_i), .reset_n_i(reset_n_i),
    .cs_n_i(cs_n), .sclk_i(sclk), .si_i(si), .short_fault_latch_disable_i(sfld),
    .short_i(short_v), .open_load_i(open_v), .chan_on_o(chan_on), .so_o(so),
    .so_oe_o(so_oe));
  ossc_host_model host (.clock_i(clock_i), .so_i(so), .so_oe_i(so_oe), .cs_n_o(cs_n),
    .sclk_o(sclk), .si_o(si), .rx_word_o(rx_word), .rx_valid_o(rx_valid));

  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end

  task automatic check(input ossc_cnt_t seen, input ossc_cnt_t want);
    num_checks++;
    if (seen !== want) begin
      miscompares++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  task automatic close_out();
    $display("checks=%0d miscompares=%0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // drain status: on shows the short flag, off shows high unless open or open-latched
  function automatic ossc_chan_t stat(input ossc_chan_t on);
    return (on & short_v) | (~on & ~open_v & ~lat_exp);
  endfunction

  // one command frame; the returned status is noted first
  task automatic frame(input ossc_chan_t c);
    exp_q.push_back({8'h00, stat(on_exp)});
    host.xfer({8'h00, c}, 8);
    on_exp = ~c;
    lat_exp = 8'h00;  // select rise clears the fault latches
    check({8'h00, chan_on}, {8'h00, on_exp});
  endtask

  task automatic settle();
    repeat (DLY + 12) @(negedge clock_i);
  endtask

  // ****************************************
  // monitor: oldest note against each received word
  // ****************************************
  always @(posedge rx_valid) begin
    if (exp_q.size() == 0) check(rx_word, 16'hffff);
    else check(rx_word, exp_q.pop_front());
  end

  initial begin
    #100000;
    miscompares++;
    close_out();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    reset_n_i = 1'b0;
    sfld = 1'b0;
    short_v = 8'h00;
    open_v = 8'h00;
    on_exp = 8'h00;
    lat_exp = 8'h00;
    cmd = 8'h00;
    void'($urandom(33003));
    repeat (5) @(negedge clock_i);
    check({8'h00, chan_on}, 16'h0000);
    check({15'h0000, so_oe}, 16'h0000);
    reset_n_i = 1'b1;
    repeat (2) @(negedge clock_i);
    for (int k = 0; k < 6; k++) begin
      cmd = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : ossc_chan_t'($urandom);
      frame(cmd);
    end
    // chain of two: own status first, then the earlier byte passes on
    cmd = ossc_chan_t'($urandom);
    exp_q.push_back({stat(on_exp), 8'h5a});
    host.xfer({8'h5a, cmd}, 16);
    on_exp = ~cmd;
    check({8'h00, chan_on}, {8'h00, on_exp});
    // short on an on channel latches off only after the delay
    short_v = 8'h08;
    frame(8'hf7);
    settle();
    on_exp[3] = 1'b0;
    check({8'h00, chan_on}, {8'h00, on_exp});
    sfld = 1'b1;
    frame(8'hf7);
    settle();
    check({8'h00, chan_on}, 16'h0008);
    sfld = 1'b0;
    short_v = 8'h00;
    // open load while deselected disables only that channel
    frame(8'hdf);
    open_v = 8'h20;
    repeat (10) @(negedge clock_i);
    on_exp[5] = 1'b0;
    lat_exp = 8'h20;  // stays latched until the next select rise
    check({8'h00, chan_on}, {8'h00, on_exp});
    exp_q.push_back({8'h00, stat(on_exp)});
    host.xfer({8'h00, 8'hdf}, 8);
    repeat (10) @(negedge clock_i);
    check({8'h00, chan_on}, 16'h0000);
    open_v = 8'h00;
    on_exp = 8'h00;
    frame(8'h3c);
    // reset in mid-run turns everything off
    reset_n_i = 1'b0;
    repeat (3) @(negedge clock_i);
    check({8'h00, chan_on}, 16'h0000);
    reset_n_i = 1'b1;
    on_exp = 8'h00;
    repeat (2) @(negedge clock_i);
    frame(ossc_chan_t'($urandom));
    check(16'(exp_q.size()), 16'h0000);
    close_out();
  end
endmodule
